/* verilog/bit_test_skip_params.svh */
`ifndef BIT_TEST_SKIP_PARAMS_SVH
`define BIT_TEST_SKIP_PARAMS_SVH

// Instruction word layout
`define INSN_W          12
`define OPC_HI          11
`define OPC_LO          8
`define BSEL_HI         7
`define BSEL_LO         5
`define FADDR_HI        4
`define FADDR_LO        0
`define OPC_SKIP_ZERO   4'h6
`define OPC_SKIP_ONE    4'h7
`define NOP_WORD        12'h000

`endif

/* verilog/bit_test_skip_pkg.sv */
package bit_test_skip_pkg;
  typedef logic [11:0] insn_t;
  typedef logic [4:0]  faddr_t;
  typedef logic [7:0]  data_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'h0,
    ST_CANCEL = 2'h1
  } exec_state_e;

  // Result of decoding one instruction word
  typedef struct packed {
    logic   is_test;
    logic   want_one;
    logic [2:0] bsel;
    faddr_t faddr;
  } decode_s;
endpackage : bit_test_skip_pkg

/* verilog/bit_test_decode.sv */
`timescale 1ns/1ps
`include "bit_test_skip_params.svh"

module bit_test_decode (
  input  wire bit_test_skip_pkg::insn_t   insn_in,
  output bit_test_skip_pkg::decode_s      dec_out
);
  import bit_test_skip_pkg::*;

  logic [3:0] opc;

  assign opc = insn_in[`OPC_HI:`OPC_LO];

  always_comb begin
    dec_out.is_test  = (opc == `OPC_SKIP_ZERO) || (opc == `OPC_SKIP_ONE);
    dec_out.want_one = (opc == `OPC_SKIP_ONE);
    dec_out.bsel     = insn_in[`BSEL_HI:`BSEL_LO];
    dec_out.faddr    = insn_in[`FADDR_HI:`FADDR_LO];
  end
endmodule : bit_test_decode

/* verilog/bit_test_skip_exec.sv */
`timescale 1ns/1ps
`include "bit_test_skip_params.svh"

// How it works
// - Opcode 0110 decodes bit and register; skip when that bit is 0.
// - Zero-skip replaces prefetched word by a no-op: two cycles, else one.
// - Opcode 0111 decodes bit and register; skip when that bit is 1.
// - One-skip replaces prefetched word by a no-op: two cycles, else one.

module bit_test_skip_exec (
  input  wire logic                       CLK_SYS_IN,
  input  wire logic                       SYS_RST_IN,
  input  wire bit_test_skip_pkg::insn_t   FETCH_INSN_IN,
  input  wire logic                       FETCH_VALID_IN,
  input  wire bit_test_skip_pkg::data_t   FILE_RDATA_IN,
  output bit_test_skip_pkg::faddr_t       FILE_ADDR_OUT,
  output logic                            FILE_WE_OUT,
  output logic                            STATUS_WE_OUT,
  output bit_test_skip_pkg::insn_t        EXEC_INSN_OUT,
  output logic                            EXEC_VALID_OUT,
  output logic                            SKIP_OUT
);
  import bit_test_skip_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Local signals

  decode_s                       dec;
  exec_state_e                   state_q;
  exec_state_e                   state_d;
  insn_t                         cur_q;
  logic                          cur_valid_q;
  logic [$bits(data_t)-1:0]      bit_hit;
  logic                          bit_val;
  logic                          test_live;
  logic                          cond_met;
  logic                          cancel_now;
  logic                          skip_now;
  insn_t                         exec_insn_d;
  faddr_t                        file_addr_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the word entering execution

  bit_test_decode u_decode (
    .insn_in (cur_q),
    .dec_out (dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline: word fetched last cycle executes this cycle

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      cur_q <= `NOP_WORD;
    end else begin
      cur_q <= FETCH_INSN_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      cur_valid_q <= 1'b0;
    end else begin
      cur_valid_q <= FETCH_VALID_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit select, one term per data bit

  genvar gi;
  generate
    for (gi = 0; gi < $bits(data_t); gi++) begin : g_bit_sel
      assign bit_hit[gi] = FILE_RDATA_IN[gi] && (dec.bsel == 3'(gi));
    end
  endgenerate

  assign bit_val = |bit_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Skip condition

  // A word sitting in the cancelled slot is never evaluated
  assign cancel_now = (state_q == ST_CANCEL);
  assign test_live  = cur_valid_q && dec.is_test && !cancel_now;
  assign cond_met   = (bit_val == dec.want_one);
  assign skip_now   = test_live && cond_met;

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the outputs

  assign file_addr_d = FETCH_INSN_IN[`FADDR_HI:`FADDR_LO];
  assign exec_insn_d = cancel_now ? `NOP_WORD : cur_q;

  ////////////////////////////////////////////////////////////////////////////
  // Execution state

  always_comb begin
    case (state_q)
      ST_RUN:    state_d = skip_now ? ST_CANCEL : ST_RUN;
      ST_CANCEL: state_d = ST_RUN;
      default:   state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file address

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      FILE_ADDR_OUT <= '0;
    end else begin
      FILE_ADDR_OUT <= file_addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Executed word

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      EXEC_INSN_OUT <= `NOP_WORD;
    end else begin
      EXEC_INSN_OUT <= exec_insn_d;
    end
  end

  // Cancelled slot stays valid: it executes as a no-op
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      EXEC_VALID_OUT <= 1'b0;
    end else begin
      EXEC_VALID_OUT <= cur_valid_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skip pulse

  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      SKIP_OUT <= 1'b0;
    end else begin
      SKIP_OUT <= skip_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write enables, never raised

  always_ff @(posedge CLK_SYS_IN) begin
    FILE_WE_OUT <= 1'b0;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    STATUS_WE_OUT <= 1'b0;
  end
endmodule : bit_test_skip_exec

/* verification/reg_file_model.sv */
`timescale 1ns/1ps
module reg_file_model import bit_test_skip_pkg::*; (
  input  faddr_t addr_in,
  output data_t  rdata_out
);
  assign rdata_out = {addr_in[2:0], addr_in};
endmodule : reg_file_model

/* verification/bit_test_skip_exec_asserts.sv */
`timescale 1ns/1ps
module bit_test_skip_exec_asserts import bit_test_skip_pkg::*; (
  input logic CLK_SYS_IN, SYS_RST_IN, FETCH_VALID_IN, FILE_WE_OUT, STATUS_WE_OUT, SKIP_OUT,
  input insn_t FETCH_INSN_IN, EXEC_INSN_OUT,
  input data_t FILE_RDATA_IN
);
  logic [12:0] i_q;
  wire b = FILE_RDATA_IN[i_q[7:5]];
  wire t = i_q[12] && i_q[11:9] == 3'h3 && !SKIP_OUT;
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) i_q <= '0;
    else i_q <= {FETCH_VALID_IN, FETCH_INSN_IN};
  end
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_zero_skip: assert property (t && !i_q[8] |=> SKIP_OUT == !$past(b)) else $error("skip");
  a_one_skip: assert property (t && i_q[8] |=> SKIP_OUT == $past(b)) else $error("skip");
  a_nop_slot: assert property (SKIP_OUT |=> EXEC_INSN_OUT == 12'h000) else $error("nop");
  a_one_cycle: assert property (!SKIP_OUT && i_q[12] |=> EXEC_INSN_OUT == $past(i_q[11:0])) else $error("word");
  a_no_write: assert property (!FILE_WE_OUT && !STATUS_WE_OUT) else $error("write");
endmodule : bit_test_skip_exec_asserts
bind bit_test_skip_exec bit_test_skip_exec_asserts u_chk (.*);

/* verification/bit_test_skip_exec_bench.sv */
`timescale 1ns/1ps
module bit_test_skip_exec_bench;
  import bit_test_skip_pkg::*;
  logic CLK_SYS_IN = 0, SYS_RST_IN = 1, FETCH_VALID_IN = 0, FILE_WE_OUT, STATUS_WE_OUT, EXEC_VALID_OUT, SKIP_OUT, s;
  insn_t FETCH_INSN_IN = 12'h000, EXEC_INSN_OUT;
  faddr_t FILE_ADDR_OUT;
  data_t FILE_RDATA_IN, d;
  int n_mismatch = 0, cmp_count = 0;
  initial forever #2.5 CLK_SYS_IN = ~CLK_SYS_IN;
  bit_test_skip_exec dut (
    .CLK_SYS_IN     (CLK_SYS_IN),
    .SYS_RST_IN     (SYS_RST_IN),
    .FETCH_INSN_IN  (FETCH_INSN_IN),
    .FETCH_VALID_IN (FETCH_VALID_IN),
    .FILE_RDATA_IN  (FILE_RDATA_IN),
    .FILE_ADDR_OUT  (FILE_ADDR_OUT),
    .FILE_WE_OUT    (FILE_WE_OUT),
    .STATUS_WE_OUT  (STATUS_WE_OUT),
    .EXEC_INSN_OUT  (EXEC_INSN_OUT),
    .EXEC_VALID_OUT (EXEC_VALID_OUT),
    .SKIP_OUT       (SKIP_OUT)
  );
  reg_file_model rf (.addr_in(FILE_ADDR_OUT), .rdata_out(FILE_RDATA_IN));
  task cmp_flag(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin n_mismatch++; $display("[ERR] %0t %h %h", $time, g, e); end
  endtask : cmp_flag
  task cmp_word(input insn_t g, input insn_t e);
    cmp_count++;
    if (g !== e) begin n_mismatch++; $display("[ERR] %0t %h %h", $time, g, e); end
  endtask : cmp_word
  task cmp_addr(input faddr_t g, input faddr_t e);
    cmp_count++;
    if (g !== e) begin n_mismatch++; $display("[ERR] %0t %h %h", $time, g, e); end
  endtask : cmp_addr
  task chk(input insn_t w);
    d = {w[2:0], w[4:0]};
    s = d[w[7:5]] == w[8];
    FETCH_INSN_IN = w;
    @(negedge CLK_SYS_IN);
    cmp_addr(FILE_ADDR_OUT, w[4:0]);
    FETCH_INSN_IN = 12'h713;
    @(negedge CLK_SYS_IN);
    cmp_flag(SKIP_OUT, s);
    cmp_word(EXEC_INSN_OUT, w);
    cmp_flag(EXEC_VALID_OUT, 1'b1);
    cmp_flag(FILE_WE_OUT, 1'b0);
    cmp_flag(STATUS_WE_OUT, 1'b0);
    FETCH_INSN_IN = 12'hFFF;
    @(negedge CLK_SYS_IN);
    cmp_flag(SKIP_OUT, !s);
    cmp_word(EXEC_INSN_OUT, s ? 12'h000 : 12'h713);
    cmp_flag(EXEC_VALID_OUT, 1'b1);
  endtask : chk
  task t_skip;
    for (int k = 0; k < 16; k++) chk({3'h3, k[3:0], 5'h13});
    $display("skip done");
  endtask : t_skip
  task t_refuse;
    FETCH_VALID_IN = 0;
    FETCH_INSN_IN = 12'h713;
    repeat (2) @(negedge CLK_SYS_IN);
    cmp_flag(SKIP_OUT, 1'b0);
    cmp_flag(EXEC_VALID_OUT, 1'b0);
    cmp_word(EXEC_INSN_OUT, 12'h713);
    FETCH_VALID_IN = 1;
    $display("refuse done");
  endtask : t_refuse
  task t_reset;
    SYS_RST_IN = 1;
    FETCH_INSN_IN = 12'h713;
    repeat (2) @(negedge CLK_SYS_IN);
    cmp_flag(SKIP_OUT, 1'b0);
    cmp_flag(EXEC_VALID_OUT, 1'b0);
    cmp_word(EXEC_INSN_OUT, 12'h000);
    cmp_addr(FILE_ADDR_OUT, 5'h00);
    SYS_RST_IN = 0;
    chk(12'h613);
    $display("reset done");
  endtask : t_reset
  task conclude;
    $display("%0d %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(negedge CLK_SYS_IN);
    SYS_RST_IN = 0;
    FETCH_VALID_IN = 1;
    t_skip;
    t_refuse;
    t_reset;
    conclude;
  end
  initial begin #2000; n_mismatch++; conclude; end
endmodule : bit_test_skip_exec_bench
